// ### rtl/pgc_top.sv
// Two general-purpose pins with APB configuration registers
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
module pgc_top import pgc_pkg::*; #(
  parameter int DBNC_8MS_CYC = PGC_DBNC_8MS_CYC,
  parameter int DBNC_16MS_CYC = PGC_DBNC_16MS_CYC,
  parameter int DBNC_32MS_CYC = PGC_DBNC_32MS_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Pins
  input wire logic [1:0] pad_in,
  output logic [1:0] pad_out,
  output logic [1:0] pad_oe_out,
  output logic [1:0] pullup_enable_out,
  output logic [1:0] pulldown_enable_out,
  // Alternate function signals
  input wire logic [1:0] alt_sig_in,
  output logic [1:0] alt_sig_out,
  // Edge events, one pulse per detected edge
  output logic [1:0] pin_event_out
);

  logic [7:0] cfg_r [PGC_NPINS];
  logic [7:0] cfg_nxt [PGC_NPINS];
  logic [1:0] alt_mode_enable_r, alt_mode_enable_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] prev_r, prev_nxt;
  logic [1:0] event_r, event_nxt;
  logic [1:0] dbn_level;
  logic [1:0] gp_input_mode;
  logic [1:0] gp_output_mode;
  logic [1:0] dbnc_eff [PGC_NPINS];
  logic setup_ph, access_ph, hit_pin0, hit_pin1, hit_alt, mapped;
  // Shadow count of differing samples, read by the filter checks only
  logic [PGC_CNT_W-1:0] diff_cnt_r [PGC_NPINS];
  logic [PGC_CNT_W-1:0] diff_cnt_nxt [PGC_NPINS];
  logic [PGC_CNT_W-1:0] dbnc_limit [PGC_NPINS];

  function automatic logic addr_hit(input logic [11:0] addr, input logic [9:0] idx);
    addr_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // Register image with the sampled level substituted in input mode
  function automatic logic [7:0] read_view(input logic [7:0] cfg, input logic is_in, input logic lvl);
    read_view = cfg;
    if (is_in) begin
      read_view[PGC_DI_BIT] = lvl;
    end
  endfunction

  assign setup_ph = psel_in && !penable_in;
  assign access_ph = psel_in && penable_in;
  assign hit_pin0 = addr_hit(paddr_in, PGC_IDX_PIN0);
  assign hit_pin1 = addr_hit(paddr_in, PGC_IDX_PIN1);
  assign hit_alt = addr_hit(paddr_in, PGC_IDX_ALT);
  assign mapped = hit_pin0 || hit_pin1 || hit_alt;

  // Zero wait states; read data is captured in the setup cycle
  assign pready_out = access_ph;
  assign pslverr_out = access_ph && !mapped;
  assign prdata_out = rdata_r;

  always_comb begin
    for (int i = 0; i < PGC_NPINS; i++) begin
      gp_input_mode[i] = !alt_mode_enable_r[i] && cfg_r[i][PGC_DIR_BIT];
      gp_output_mode[i] = !alt_mode_enable_r[i] && !cfg_r[i][PGC_DIR_BIT];
      // Filter parked while not a general input
      dbnc_eff[i] = gp_input_mode[i] ? cfg_r[i][PGC_DBNC_LSB +: 2] : 2'b00;
    end
  end

  // Register file
  always_comb begin
    cfg_nxt = cfg_r;
    alt_mode_enable_nxt = alt_mode_enable_r;
    rdata_nxt = rdata_r;
    if (setup_ph && !pwrite_in) begin
      rdata_nxt = 32'h0000_0000;
      if (hit_pin0) begin
        rdata_nxt[7:0] = read_view(cfg_r[0], gp_input_mode[0], dbn_level[0]);
      end else if (hit_pin1) begin
        rdata_nxt[7:0] = read_view(cfg_r[1], gp_input_mode[1], dbn_level[1]);
      end else if (hit_alt) begin
        rdata_nxt[1:0] = alt_mode_enable_r;
      end
    end
    if (access_ph && pwrite_in) begin
      for (int i = 0; i < PGC_NPINS; i++) begin
        if ((i == 0) ? hit_pin0 : hit_pin1) begin
          cfg_nxt[i] = pwdata_in[7:0];
          if (gp_input_mode[i]) begin
            cfg_nxt[i][PGC_DI_BIT] = cfg_r[i][PGC_DI_BIT];
          end
        end
      end
      if (hit_alt) begin
        alt_mode_enable_nxt = pwdata_in[1:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < PGC_NPINS; i++) begin
        cfg_r[i] <= PGC_PIN_RST;
      end
      alt_mode_enable_r <= PGC_ALT_RST;
      rdata_r <= 32'h0000_0000;
    end else begin
      cfg_r <= cfg_nxt;
      alt_mode_enable_r <= alt_mode_enable_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Per-pin filters
  genvar g;
  generate
    for (g = 0; g < PGC_NPINS; g++) begin : g_dbn
      pgc_debounce #(
        .CNT_W(PGC_CNT_W)
      ) u_dbn (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .cnt_8_in(PGC_CNT_W'(DBNC_8MS_CYC)),
        .cnt_16_in(PGC_CNT_W'(DBNC_16MS_CYC)),
        .cnt_32_in(PGC_CNT_W'(DBNC_32MS_CYC)),
        .raw_in(pad_in[g]),
        .sel_in(dbnc_eff[g]),
        .level_out(dbn_level[g])
      );
    end
  endgenerate

  // Edge events from the filtered level only
  always_comb begin
    prev_nxt = dbn_level;
    event_nxt = 2'b00;
    for (int i = 0; i < PGC_NPINS; i++) begin
      if (gp_input_mode[i]) begin
        event_nxt[i] = (cfg_r[i][PGC_IRQ_LSB] && prev_r[i] && !dbn_level[i]) ||
                       (cfg_r[i][PGC_IRQ_LSB + 1] && !prev_r[i] && dbn_level[i]);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      prev_r <= 2'b00;
      event_r <= 2'b00;
    end else begin
      prev_r <= prev_nxt;
      event_r <= event_nxt;
    end
  end

  assign pin_event_out = event_r;

  // Check helper: samples seen since the filtered level last matched the pad
  always_comb begin
    for (int i = 0; i < PGC_NPINS; i++) begin
      case (dbnc_eff[i])
        PGC_DB_8MS: dbnc_limit[i] = PGC_CNT_W'(DBNC_8MS_CYC);
        PGC_DB_16MS: dbnc_limit[i] = PGC_CNT_W'(DBNC_16MS_CYC);
        PGC_DB_32MS: dbnc_limit[i] = PGC_CNT_W'(DBNC_32MS_CYC);
        default: dbnc_limit[i] = '0;
      endcase
      diff_cnt_nxt[i] = '0;
      if (pad_in[i] != dbn_level[i]) begin
        // Saturates so a long-floating pin cannot wrap back into range
        diff_cnt_nxt[i] = (diff_cnt_r[i] == '1) ? diff_cnt_r[i] : diff_cnt_r[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < PGC_NPINS; i++) begin
        diff_cnt_r[i] <= '0;
      end
    end else begin
      diff_cnt_r <= diff_cnt_nxt;
    end
  end

  // Pad drive, pulls and alternate signals
  always_comb begin
    for (int i = 0; i < PGC_NPINS; i++) begin
      pad_out[i] = 1'b0;
      pad_oe_out[i] = 1'b0;
      pullup_enable_out[i] = 1'b0;
      pulldown_enable_out[i] = 1'b0;
      alt_sig_out[i] = 1'b0;
      if (alt_mode_enable_r[i]) begin
        if (PGC_ALT_IS_OUT[i]) begin
          // Direction bit may be 0 or 1 here and is not consulted
          pad_out[i] = alt_sig_in[i];
          pad_oe_out[i] = 1'b1;
        end else begin
          alt_sig_out[i] = cfg_r[i][PGC_DIR_BIT] ? pad_in[i] : !pad_in[i];
        end
      end else if (gp_output_mode[i]) begin
        if (!cfg_r[i][PGC_DO_BIT]) begin
          pad_oe_out[i] = 1'b1;
        end else begin
          pad_out[i] = cfg_r[i][PGC_DRV_BIT];
          pad_oe_out[i] = cfg_r[i][PGC_DRV_BIT];
        end
      end else begin
        // Drive type plays no part for an input
        pullup_enable_out[i] = !cfg_r[i][PGC_DO_BIT];
        pulldown_enable_out[i] = cfg_r[i][PGC_DO_BIT];
      end
    end
  end

  // Checks
  generate
    for (g = 0; g < PGC_NPINS; g++) begin : g_chk
      a_out_low_drive: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_output_mode[g] && !cfg_r[g][PGC_DO_BIT] |-> pad_oe_out[g] && !pad_out[g])
        else $error("output level 0 not driven low");
      a_od_release: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_output_mode[g] && cfg_r[g][PGC_DO_BIT] |-> pad_oe_out[g] == cfg_r[g][PGC_DRV_BIT])
        else $error("drive type not honoured for level 1");
      a_input_pulls: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_input_mode[g] |-> !pad_oe_out[g] && (pulldown_enable_out[g] == cfg_r[g][PGC_DO_BIT])
          && (pullup_enable_out[g] != pulldown_enable_out[g]))
        else $error("input mode pulls or drive wrong");
      a_di_write_drop: assert property (@(posedge clk_in) disable iff (!nrst_in)
        access_ph && pwrite_in && mapped && gp_input_mode[g] |=> $stable(cfg_r[g][PGC_DI_BIT]))
        else $error("input level bit written in input mode");
      a_event_only_input: assert property (@(posedge clk_in) disable iff (!nrst_in)
        pin_event_out[g] |-> $past(gp_input_mode[g]))
        else $error("pin event outside input mode");
      a_rise_event: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_input_mode[g] && cfg_r[g][PGC_IRQ_LSB + 1] && $rose(dbn_level[g]) |=> pin_event_out[g])
        else $error("rising edge event missed");
      a_no_filter_pass: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_input_mode[g] && dbnc_eff[g] == 2'b00 |=> dbn_level[g] == $past(pad_in[g]))
        else $error("unfiltered level not following pad");
      a_fall_event: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_input_mode[g] && cfg_r[g][PGC_IRQ_LSB] && $fell(dbn_level[g]) |=> pin_event_out[g])
        else $error("falling edge event missed");
      a_rise_masked: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_input_mode[g] && !cfg_r[g][PGC_IRQ_LSB + 1] && $rose(dbn_level[g]) |=> !pin_event_out[g])
        else $error("masked rising edge raised an event");
      a_fall_masked: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_input_mode[g] && !cfg_r[g][PGC_IRQ_LSB] && $fell(dbn_level[g]) |=> !pin_event_out[g])
        else $error("masked falling edge raised an event");
      a_no_out_event: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_output_mode[g] |=> !pin_event_out[g])
        else $error("pin event while a general output");
      a_out_filter_off: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_output_mode[g] |=> dbn_level[g] == $past(pad_in[g]))
        else $error("filter active on a general output");
      a_filter_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_input_mode[g] && dbnc_eff[g] != 2'b00 && pad_in[g] == dbn_level[g] |=> $stable(dbn_level[g]))
        else $error("filtered level moved without a pad change");
      a_filter_early: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_input_mode[g] && dbnc_eff[g] != 2'b00 && ({1'b0, diff_cnt_r[g]} + 1'b1 < {1'b0, dbnc_limit[g]})
          |=> $stable(dbn_level[g]))
        else $error("level accepted before the settling time");
      a_high_level: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_output_mode[g] && cfg_r[g][PGC_DO_BIT] |-> pad_out[g] == cfg_r[g][PGC_DRV_BIT])
        else $error("output level 1 drive value wrong");
      a_input_no_drive: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_input_mode[g] |-> !pad_oe_out[g] && !pad_out[g])
        else $error("general input drives its pin");
      a_output_no_pull: assert property (@(posedge clk_in) disable iff (!nrst_in)
        gp_output_mode[g] |-> !pullup_enable_out[g] && !pulldown_enable_out[g])
        else $error("pull enabled on a general output");
      a_di_read_level: assert property (@(posedge clk_in) disable iff (!nrst_in)
        setup_ph && !pwrite_in && ((g == 0) ? hit_pin0 : hit_pin1) && gp_input_mode[g]
          |=> prdata_out[PGC_DI_BIT] == $past(dbn_level[g]))
        else $error("input level bit does not read the pin");
      if (PGC_ALT_IS_OUT[g]) begin : g_ao
        a_alt_out_high: assert property (@(posedge clk_in) disable iff (!nrst_in)
          alt_mode_enable_r[g] |-> pad_oe_out[g] && pad_out[g] == alt_sig_in[g])
          else $error("alternate output not active-high");
      end else begin : g_ai
        a_alt_in_pol: assert property (@(posedge clk_in) disable iff (!nrst_in)
          alt_mode_enable_r[g] |-> alt_sig_out[g] == (pad_in[g] ~^ cfg_r[g][PGC_DIR_BIT]))
          else $error("alternate input polarity wrong");
        a_alt_in_float: assert property (@(posedge clk_in) disable iff (!nrst_in)
          alt_mode_enable_r[g] |-> !pad_oe_out[g])
          else $error("alternate input pin driven");
      end
      c_fall_event: cover property (@(posedge clk_in) disable iff (!nrst_in)
        gp_input_mode[g] && $fell(dbn_level[g]) ##1 pin_event_out[g]);
      c_od_release: cover property (@(posedge clk_in) disable iff (!nrst_in)
        gp_output_mode[g] && cfg_r[g][PGC_DO_BIT] && !pad_oe_out[g]);
    end
  endgenerate

  c_bad_addr: cover property (@(posedge clk_in) disable iff (!nrst_in) pslverr_out);
  c_alt_mode: cover property (@(posedge clk_in) disable iff (!nrst_in) alt_mode_enable_r == 2'b11);

endmodule

// ### rtl/pgc_pkg.sv
// Constants and types for the two-pin general-purpose pin configuration block
// Summary of operation
// - In input mode the debounce selector filters both edges: 00 none, 01 8 ms, 10 16 ms, 11 32 ms.
// - In general output mode the debounce selector has no effect.
// - In input mode the edge selector gives 00 no event, 01 falling, 10 rising, 11 both edges.
// - In general output mode the edge selector is ignored and no pin event is raised.
// - In output mode level 0 drives low, level 1 drives high in push-pull or releases the pin in open-drain.
// - In input mode the output level bit picks the pull: 0 pull-up, 1 pull-down.
// - In input mode the input level bit reads the sampled pin state.
// - In input mode software writes to the input level bit are discarded.
// - Without alternate function the direction bit means 0 general output, 1 general input.
// - An alternate output is always driven active-high whatever the direction bit says.
// - For an alternate input the direction bit sets polarity: 0 active-low, 1 active-high.
// - In output mode the drive type bit picks 0 open-drain, 1 push-pull.
// - In general input mode the drive type bit is ignored.
package pgc_pkg;

  localparam int PGC_NPINS = 2;

  // Register indexes; byte address is four times the index
  localparam logic [9:0] PGC_IDX_PIN0 = 10'h070;
  localparam logic [9:0] PGC_IDX_PIN1 = 10'h071;
  localparam logic [9:0] PGC_IDX_ALT = 10'h07f;

  // Field positions inside a pin register
  localparam int PGC_DBNC_LSB = 6;
  localparam int PGC_IRQ_LSB = 4;
  localparam int PGC_DO_BIT = 3;
  localparam int PGC_DI_BIT = 2;
  localparam int PGC_DIR_BIT = 1;
  localparam int PGC_DRV_BIT = 0;

  localparam logic [7:0] PGC_PIN_RST = 8'h00;
  localparam logic [1:0] PGC_ALT_RST = 2'h0;

  // Which pins act as alternate outputs; the others are alternate inputs
  localparam logic [1:0] PGC_ALT_IS_OUT = 2'h2;

  // Debounce times and their cycle counts at the 4 ns clock, rounded up
  localparam int PGC_CLK_PERIOD_NS = 4;
  localparam int PGC_DBNC_8MS_NS = 8000000;
  localparam int PGC_DBNC_16MS_NS = 16000000;
  localparam int PGC_DBNC_32MS_NS = 32000000;
  localparam int PGC_DBNC_8MS_CYC = (PGC_DBNC_8MS_NS + PGC_CLK_PERIOD_NS - 1) / PGC_CLK_PERIOD_NS;
  localparam int PGC_DBNC_16MS_CYC = (PGC_DBNC_16MS_NS + PGC_CLK_PERIOD_NS - 1) / PGC_CLK_PERIOD_NS;
  localparam int PGC_DBNC_32MS_CYC = (PGC_DBNC_32MS_NS + PGC_CLK_PERIOD_NS - 1) / PGC_CLK_PERIOD_NS;
  localparam int PGC_CNT_W = 24;

  typedef enum logic [1:0] {
    PGC_DB_NONE = 2'b00,
    PGC_DB_8MS = 2'b01,
    PGC_DB_16MS = 2'b10,
    PGC_DB_32MS = 2'b11
  } pgc_dbnc_e;

  typedef enum logic [1:0] {
    PGC_EDGE_MASK = 2'b00,
    PGC_EDGE_FALL = 2'b01,
    PGC_EDGE_RISE = 2'b10,
    PGC_EDGE_BOTH = 2'b11
  } pgc_edge_e;

endpackage

// ### rtl/pgc_debounce.sv
// Debounce filter for one pin with a selectable settling time
`timescale 1ns/100ps
module pgc_debounce import pgc_pkg::*; #(
  parameter int CNT_W = PGC_CNT_W
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Settling counts per code
  input wire logic [CNT_W-1:0] cnt_8_in,
  input wire logic [CNT_W-1:0] cnt_16_in,
  input wire logic [CNT_W-1:0] cnt_32_in,
  // Raw level and selection
  input wire logic raw_in,
  input wire logic [1:0] sel_in,
  // Filtered level
  output logic level_out
);

  logic level_r, level_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] limit;

  always_comb begin
    case (pgc_dbnc_e'(sel_in))
      PGC_DB_8MS: limit = cnt_8_in;
      PGC_DB_16MS: limit = cnt_16_in;
      PGC_DB_32MS: limit = cnt_32_in;
      default: limit = '0;
    endcase
    level_nxt = level_r;
    cnt_nxt = '0;
    if (sel_in == PGC_DB_NONE) begin
      level_nxt = raw_in;
    end else if (raw_in != level_r) begin
      // New level must hold for the whole window before it is accepted
      if (cnt_r + 1'b1 >= limit) begin
        level_nxt = raw_in;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      level_r <= 1'b0;
      cnt_r <= '0;
    end else begin
      level_r <= level_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign level_out = level_r;

endmodule

// ### verif/pgc_pin_model.sv
// Board-side model of the two pins: resolves the wire level from all drivers
`timescale 1ns/100ps
module pgc_pin_model (
  // Clock
  input wire logic clk_in,
  // Device side of the pins
  input wire logic [1:0] pad_out_in,
  input wire logic [1:0] pad_oe_in,
  input wire logic [1:0] pullup_in,
  input wire logic [1:0] pulldown_in,
  // Board drivers
  input wire logic [1:0] ext_en_in,
  input wire logic [1:0] ext_lv_in,
  // Resolved level
  output logic [1:0] level_out
);
  logic [1:0] last_r = 2'h0;
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (pad_oe_in[i])
        level_out[i] = pad_out_in[i];
      else if (ext_en_in[i])
        level_out[i] = ext_lv_in[i];
      else if (pullup_in[i])
        level_out[i] = 1'b1;
      else if (pulldown_in[i])
        level_out[i] = 1'b0;
      else
        // Floating pin toggles so a stale level is never trusted
        level_out[i] = ~last_r[i];
    end
  end
  always_ff @(posedge clk_in) begin
    last_r <= level_out;
  end
endmodule

// ### verif/tb.sv
// Self-checking bench for the two-pin configuration block
`timescale 1ns/100ps
module tb import pgc_pkg::*;;
  localparam logic [11:0] A0 = {PGC_IDX_PIN0, 2'b00};
  localparam logic [11:0] A1 = {PGC_IDX_PIN1, 2'b00};
  localparam logic [11:0] AALT = {PGC_IDX_ALT, 2'b00};
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, ev = 32'h0, ev1 = 32'h0, e0;
  logic [1:0] pad_lv, pad_out, pad_oe, pu, pd, alt_out, ev_out;
  logic [1:0] alt_in = 2'h0, ext_en = 2'h0, ext_lv = 2'h0;
  int errors = 0, total_checks = 0;
  int ncyc [3] = '{5, 10, 20};

  initial forever #2 clk_in = ~clk_in;
  always @(posedge clk_in) ev <= ev + 32'(ev_out[0]);
  always @(posedge clk_in) ev1 <= ev1 + 32'(ev_out[1]);

  pgc_top #(.DBNC_8MS_CYC(5), .DBNC_16MS_CYC(10), .DBNC_32MS_CYC(20)) DUT (
    .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .pad_in(pad_lv), .pad_out(pad_out),
    .pad_oe_out(pad_oe), .pullup_enable_out(pu), .pulldown_enable_out(pd),
    .alt_sig_in(alt_in), .alt_sig_out(alt_out), .pin_event_out(ev_out));
  pgc_pin_model PM (.clk_in(clk_in), .pad_out_in(pad_out), .pad_oe_in(pad_oe),
    .pullup_in(pu), .pulldown_in(pd), .ext_en_in(ext_en), .ext_lv_in(ext_lv), .level_out(pad_lv));

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      $display("BAD at %0t: no ready", $time);
      wrap_up();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task cfg(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
    cyc(2);
  endtask
  task rchk(input logic [11:0] a, input logic [7:0] d);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, d});
    chk(err, 1'b0);
  endtask
  task setp(input logic v);
    @(posedge clk_in) ext_lv[0] <= v;
  endtask

  initial begin
    #100000;
    errors++;
    $display("BAD at %0t: run too long", $time);
    wrap_up();
  end

  initial begin
    cyc(12);
    chk({pad_oe, pad_out}, 4'hc);
    @(posedge clk_in) nrst_in <= 1'b1;
    rchk(A0, 8'h00);
    rchk(A1, 8'h00);
    $display("test reset done");
    cfg(A0, 8'h09);
    chk({pad_oe[0], pad_out[0]}, 2'b11);
    cfg(A0, 8'h08);
    chk(pad_oe[0], 1'b0);
    cfg(A0, 8'h01);
    chk({pad_oe[0], pad_out[0]}, 2'b10);
    // Open-drain released so the board can wiggle the pin
    cfg(A0, 8'hf8);
    @(posedge clk_in) ext_en <= 2'b11;
    e0 = ev;
    setp(1'b1);
    cyc(30);
    setp(1'b0);
    cyc(30);
    chk(ev - e0, 0);
    $display("test output done");
    cfg(A0, 8'h03);
    chk({pu[0], pd[0], pad_oe[0]}, 3'b100);
    cfg(A1, 8'h0a);
    chk({pu[1], pd[1]}, 2'b01);
    cfg(A1, 8'h2a);
    e0 = ev1;
    @(posedge clk_in) ext_lv[1] <= 1'b1;
    cyc(5);
    chk(ev1 - e0, 1);
    @(posedge clk_in) ext_lv[1] <= 1'b0;
    cyc(5);
    chk(ev1 - e0, 1);
    cfg(A0, 8'h06);
    rchk(A0, 8'h02);
    setp(1'b1);
    cyc(4);
    cfg(A0, 8'h02);
    rchk(A0, 8'h06);
    setp(1'b0);
    cyc(4);
    for (int s = 0; s < 4; s++) begin
      cfg(A0, 8'h02 | 8'(s << 4));
      e0 = ev;
      setp(1'b1);
      cyc(5);
      chk(ev - e0, 32'(s >> 1));
      e0 = ev;
      setp(1'b0);
      cyc(5);
      chk(ev - e0, 32'(s & 1));
    end
    $display("test edges done");
    for (int c = 1; c < 4; c++) begin
      cfg(A0, 8'(c << 6) | 8'h32);
      e0 = ev;
      // Glitch shorter than the settling time
      setp(1'b1);
      cyc(ncyc[c-1] - 3);
      setp(1'b0);
      cyc(3 * ncyc[c-1]);
      chk(ev - e0, 0);
      setp(1'b1);
      cyc(ncyc[c-1] + 4);
      rchk(A0, 8'(c << 6) | 8'h36);
      chk(ev - e0, 1);
      setp(1'b0);
      cyc(ncyc[c-1] + 4);
      chk(ev - e0, 2);
    end
    $display("test debounce done");
    cfg(AALT, 8'h03);
    cfg(A0, 8'h32);
    setp(1'b1);
    cyc(3);
    chk(alt_out[0], 1'b1);
    setp(1'b0);
    cyc(3);
    chk(alt_out[0], 1'b0);
    cfg(A0, 8'h30);
    chk(alt_out[0], 1'b1);
    cfg(A1, 8'h00);
    @(posedge clk_in) alt_in <= 2'b10;
    cyc(2);
    chk({pad_oe[1], pad_out[1]}, 2'b11);
    cfg(A1, 8'h02);
    chk(pad_out[1], 1'b1);
    @(posedge clk_in) alt_in <= 2'b00;
    cyc(2);
    chk({pad_oe[1], pad_out[1]}, 2'b10);
    $display("test alternate done");
    apb(1'b1, 12'h100, 32'hff);
    chk(err, 1'b1);
    apb(1'b0, 12'h1c1, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    rchk(A0, 8'h30);
    $display("test unmapped done");
    wrap_up();
  end
endmodule
